// >>> core/ssp_serial_port.sv
// Purpose: SPI / software-assisted two-wire serial port with register port
// Assumes: Clock pin is looped back on sck_in; SDA is DIN and DOUT joined
// Notes:   Line edges are seen on link_clk_in and cross as toggles

// Function
// - Master/slave, full duplex, both polarities, phases, orders
// - Master clock from software, strobe or timers
// - Gating bit decides whether slave-select matters
// - Slave-select high freezes shifting and counting
// - Slave data-out driven only while select low
// - Count event when bit counter reaches eight
// - Data register access clears count event
// - Bit counter readable in control register
// - New transfer drops pending event, overwrites data
// - Power-down bit releases pins to general I/O
// - Count event bit 2, start/stop bit 3
// - Two-wire start or stop raises event
// - Two-wire counter: falling clock, reset on access/start/stop
// - Two-wire event after byte, after ack, optionally per bit
// - Master writes FF to clock acknowledge bit
// - Receive on rising clock; 7F acks, FF nacks
// - Stretch disable blocks stretching/events, start clears it
// - Slave transmit stretches clock until data written
// - Slave receive starts after FF write, then stretches
// - Two-wire data write clears event and stretch
module ssp_serial_port (
    input  wire logic       ref_clk_in,        // System clock
    input  wire logic       rst_b_in,          // Asynchronous reset, active low
    input  wire logic       link_clk_in,       // Link sampling clock
    input  wire logic [7:0] sfr_addr_in,       // Register address
    input  wire logic [7:0] sfr_wdata_in,      // Register write data
    input  wire logic       sfr_wr_in,         // Register write strobe
    input  wire logic       sfr_rd_in,         // Register read strobe
    output logic      [7:0] sfr_rdata_out,     // Register read data
    input  wire logic       timer0_expiry_in,  // Timer 0 expiry pulse
    input  wire logic       timer1_expiry_in,  // Timer 1 expiry pulse
    input  wire logic       ext_move_wr_in,    // External move write strobe, high active
    input  wire logic       ss_b_in,           // Slave-select pin, active low
    input  wire logic       sck_in,            // Serial clock pin level
    input  wire logic       din_in,            // Data-in pin level
    output logic            sck_out,           // Serial clock drive value
    output logic            sck_oe_b_out,      // Serial clock enable, low drives
    output logic            dout_out,          // Data-out drive value
    output logic            dout_oe_b_out,     // Data-out enable, low drives
    output logic            gpio_release_out,  // Pins handed back to general I/O
    output logic            count_event_out,   // Count event flag
    output logic            startstop_event_out // Start/stop event flag
);

    // ---------------- Link domain ----------------
    logic [2:0] lk_sck_reg;                    // Clock pin sync plus history
    logic [2:0] lk_din_reg;                    // Data pin sync plus history
    logic [3:0] lk_tog_reg;                    // Event toggles {rise,fall,start,stop}
    logic       lk_din_cap_reg;                // Data level at the last clock edge
    ssp_pkg::ssp_evt_s lk_evt;                 // Edge detections in link domain

    // Edge detection reads only the second and third stages
    assign lk_evt.rise  = lk_sck_reg[1] & ~lk_sck_reg[2];
    assign lk_evt.fall  = ~lk_sck_reg[1] & lk_sck_reg[2];
    assign lk_evt.start = lk_sck_reg[1] & lk_sck_reg[2] & lk_din_reg[2] & ~lk_din_reg[1];
    assign lk_evt.stop  = lk_sck_reg[1] & lk_sck_reg[2] & ~lk_din_reg[2] & lk_din_reg[1];

    // Pin synchronisers and event toggles
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lk_sck_reg     <= 3'h0;
            lk_din_reg     <= 3'h7;
            lk_tog_reg     <= 4'h0;
            lk_din_cap_reg <= 1'b0;
        end else begin
            lk_sck_reg <= {lk_sck_reg[1:0], sck_in};
            lk_din_reg <= {lk_din_reg[1:0], din_in};
            lk_tog_reg <= lk_tog_reg ^ lk_evt;
            // Data is held stable until the next edge, so the din_sync_reg level synchroniser carries it safely
            if (lk_evt.rise | lk_evt.fall) begin
                lk_din_cap_reg <= lk_din_reg[1];
            end
        end
    end

    // ---------------- System domain: crossing ----------------
    logic [3:0] tog_s1_reg;                    // First sync stage
    logic [3:0] tog_s2_reg;                    // Second sync stage
    logic [3:0] tog_s3_reg;                    // Edge history
    logic [1:0] ss_sync_reg;                   // Slave-select synchroniser
    logic [1:0] din_sync_reg;                  // Carries link data sample
    ssp_pkg::ssp_evt_s evt;                    // One-cycle events in system domain

    // One pulse per toggle change, one per event bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_evt
            assign evt[gi] = tog_s2_reg[gi] ^ tog_s3_reg[gi];
        end
    endgenerate

    // Toggle and level synchronisers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tog_s1_reg   <= 4'h0;
            tog_s2_reg   <= 4'h0;
            tog_s3_reg   <= 4'h0;
            ss_sync_reg  <= 2'h3;
            din_sync_reg <= 2'h0;
        end else begin
            tog_s1_reg   <= lk_tog_reg;
            tog_s2_reg   <= tog_s1_reg;
            tog_s3_reg   <= tog_s2_reg;
            ss_sync_reg  <= {ss_sync_reg[0], ss_b_in};
            din_sync_reg <= {din_sync_reg[0], lk_din_cap_reg};
        end
    end

    // ---------------- Registers ----------------
    logic [7:0] ctrl_reg;                      // Serial control fields
    logic [7:0] power_reg;                     // Peripheral power control
    logic [7:0] clksrc_reg;                    // Clock source select
    logic [7:0] shift_reg;                     // Shared shift register
    logic [3:0] count_reg;                     // Bit counter
    logic       count_flag_reg;                // Pending count event
    logic       stsp_flag_reg;                 // Pending start/stop event
    logic       stretch_reg;                   // Holding clock low
    logic       armed_reg;                     // Slave allowed to shift
    logic       out_bit_reg;                   // Bit presented on the data line
    logic       sck_level_reg;                 // Master clock level
    logic [7:0] shift_next;
    logic [3:0] count_next;
    logic       out_bit_next;
    logic       sck_level_next;
    ssp_pkg::ssp_ctrl_s ctl;                   // Decoded control

    assign ctl = ctrl_reg;

    // Bit presented first or next, per bit order
    function automatic logic head_bit(input logic [7:0] data, input logic lsb);
        head_bit = lsb ? data[0] : data[7];
    endfunction : head_bit

    // Shift in on the sampling side of the chosen order
    function automatic logic [7:0] shift_in(input logic [7:0] data, input logic lsb,
                                            input logic bit_in);
        shift_in = lsb ? {bit_in, data[7:1]} : {data[6:0], bit_in};
    endfunction : shift_in

    // ---------------- Register port decode ----------------
    wire powered_down = power_reg[ssp_pkg::POWER_SER_BIT];
    wire run          = ~powered_down;
    wire wr_ctrl   = sfr_wr_in & (sfr_addr_in == ssp_pkg::SERIAL_CTRL_ADDR);
    wire wr_tw     = sfr_wr_in & (sfr_addr_in == ssp_pkg::TWOWIRE_DATA_ADDR);
    wire wr_sd     = sfr_wr_in & (sfr_addr_in == ssp_pkg::SERIAL_DATA_ADDR);
    wire wr_aux    = sfr_wr_in & (sfr_addr_in == ssp_pkg::AUX_INT_ADDR);
    wire wr_power  = sfr_wr_in & (sfr_addr_in == ssp_pkg::POWER_CTRL_ADDR);
    wire wr_clksrc = sfr_wr_in & (sfr_addr_in == ssp_pkg::CLK_SRC_ADDR);
    wire rd_data   = sfr_rd_in & ((sfr_addr_in == ssp_pkg::TWOWIRE_DATA_ADDR) |
                                  (sfr_addr_in == ssp_pkg::SERIAL_DATA_ADDR));
    wire wr_data   = wr_tw | wr_sd;
    wire data_access = rd_data | wr_data;

    // Read mux; unmapped addresses read zero
    logic [7:0] rdata_next;
    always_comb begin
        case (sfr_addr_in)
            ssp_pkg::SERIAL_CTRL_ADDR:  rdata_next = {ctrl_reg[7:4], count_reg};
            ssp_pkg::TWOWIRE_DATA_ADDR: rdata_next = shift_reg;
            ssp_pkg::SERIAL_DATA_ADDR:  rdata_next = shift_reg;
            ssp_pkg::AUX_INT_ADDR:      rdata_next = {4'h0, stsp_flag_reg, count_flag_reg, 2'h0};
            ssp_pkg::POWER_CTRL_ADDR:   rdata_next = power_reg;
            ssp_pkg::CLK_SRC_ADDR:      rdata_next = clksrc_reg;
            default:                    rdata_next = 8'h00;
        endcase
    end

    // ---------------- Edge roles ----------------
    wire in_i2c   = run & ctl.i2c;
    wire in_spi   = run & ~ctl.i2c;
    wire i2c_slave = in_i2c & ~ctl.master;
    // Two-wire start/stop seen only in two-wire mode
    wire start_ev = in_i2c & evt.start;
    wire stop_ev  = in_i2c & evt.stop;
    // Leading edge leaves the idle level; phase picks which edge samples
    wire spi_samp_rise = ~(ctl.cpol ^ ctl.cpha);
    wire samp_ev  = ctl.i2c ? evt.rise : (spi_samp_rise ? evt.rise : evt.fall);
    wire drive_ev = ctl.i2c ? evt.fall : (spi_samp_rise ? evt.fall : evt.rise);
    // Slave-select freezes slave when gating is on; select ignored when off
    wire ss_open  = ctl.master | ~ctl.select_gating_enable | ~ss_sync_reg[1];
    // Two-wire slave shifts only once armed and while not stretching
    wire tw_open  = ctl.master | (armed_reg & ~stretch_reg);
    wire gate     = ctl.i2c ? tw_open : ss_open;
    wire do_samp  = run & samp_ev & gate;
    wire do_drive = run & drive_ev & gate;
    wire spi_new  = in_spi & do_samp & (count_reg == ssp_pkg::CNT_BYTE);
    // Counter step: sampling edge in SPI, falling edge in two-wire
    wire cnt_step = in_spi ? do_samp : (in_i2c & evt.fall & gate);
    wire tw_quiet = ctl.nostretch;

    // Bit counter next value
    always_comb begin
        count_next = count_reg;
        if (in_i2c & (data_access | start_ev | stop_ev)) begin
            count_next = 4'h0;
        end else if (in_spi & wr_data) begin
            count_next = 4'h0;
        end else if (spi_new) begin
            count_next = ssp_pkg::CNT_FIRST;
        end else if (cnt_step) begin
            count_next = 4'(count_reg + 4'h1);
        end
    end

    // Completion conditions raise the count event
    wire spi_done = in_spi & cnt_step & (count_next == ssp_pkg::CNT_BYTE);
    wire tw_done  = in_i2c & cnt_step & ~tw_quiet &
                    ((count_next == ssp_pkg::CNT_BYTE) |
                     (count_next == ssp_pkg::CNT_ACK) | ctl.onebit);
    wire count_set = spi_done | tw_done;
    // Slave stretches after byte or acknowledge unless disabled
    wire stretch_set = i2c_slave & tw_done & ~tw_quiet;

    // Shift register: write loads, sampling shifts the line in
    always_comb begin
        shift_next   = shift_reg;
        out_bit_next = out_bit_reg;
        if (wr_data) begin
            shift_next   = sfr_wdata_in;
            out_bit_next = head_bit(sfr_wdata_in, ctl.lsb & ~ctl.i2c);
        end else if (do_samp) begin
            // Received bits displace sent bits in the one register
            shift_next = shift_in(shift_reg, ctl.lsb & ~ctl.i2c, din_sync_reg[1]);
        end else if (do_drive) begin
            out_bit_next = head_bit(shift_reg, ctl.lsb & ~ctl.i2c);
        end
    end

    // Master clock: timer pulse sources follow the strobe, write pulse source inverts it, toggle sources flip
    always_comb begin
        case (ssp_pkg::ssp_clk_src_e'(clksrc_reg[2:0]))
            ssp_pkg::SRC_SOFTWARE:  sck_level_next = clksrc_reg[ssp_pkg::CLKSRC_SW_BIT];
            ssp_pkg::SRC_WR_PULSE:  sck_level_next = ~ext_move_wr_in;
            ssp_pkg::SRC_WR_TOGGLE: sck_level_next = sck_level_reg ^ ext_move_wr_in;
            ssp_pkg::SRC_T0_PULSE:  sck_level_next = timer0_expiry_in;
            ssp_pkg::SRC_T0_TOGGLE: sck_level_next = sck_level_reg ^ timer0_expiry_in;
            ssp_pkg::SRC_T1_PULSE:  sck_level_next = timer1_expiry_in;
            ssp_pkg::SRC_T1_TOGGLE: sck_level_next = sck_level_reg ^ timer1_expiry_in;
            ssp_pkg::SRC_IDLE:      sck_level_next = ctl.cpol;
            default:                sck_level_next = ctl.cpol;
        endcase
    end

    // Pin drive: enables are low while driving
    wire master_drive = run & ctl.master;
    // SPI slave data-out follows select only when gating is on
    wire spi_dout_en  = in_spi & (ctl.master | ~ctl.select_gating_enable | ~ss_sync_reg[1]);
    wire dout_oe_b_next = in_i2c ? out_bit_reg : ~spi_dout_en;
    wire dout_next      = in_i2c ? 1'b0 : out_bit_reg;
    // Two-wire clock is open drain; stretching pulls it low
    wire sck_oe_b_next  = in_i2c ? (ctl.master ? sck_level_reg : ~stretch_reg)
                                 : ~master_drive;
    wire sck_next       = in_i2c ? 1'b0 : sck_level_reg;

    // Configuration registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_reg   <= ssp_pkg::CTRL_RESET;
            power_reg  <= ssp_pkg::POWER_RESET;
            clksrc_reg <= ssp_pkg::CLKSRC_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= sfr_wdata_in;
            end else if (start_ev) begin
                ctrl_reg[ssp_pkg::CTRL_NOSTR_BIT] <= 1'b0;
            end
            if (wr_power) begin
                power_reg <= sfr_wdata_in;
            end
            if (wr_clksrc) begin
                clksrc_reg <= sfr_wdata_in;
            end
        end
    end

    // Shift path and counter
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shift_reg     <= ssp_pkg::DATA_RESET;
            count_reg     <= 4'h0;
            out_bit_reg   <= 1'b1;
            sck_level_reg <= 1'b0;
        end else begin
            shift_reg     <= shift_next;
            count_reg     <= count_next;
            out_bit_reg   <= out_bit_next;
            sck_level_reg <= sck_level_next;
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_flag_reg <= 1'b0;
            stsp_flag_reg  <= 1'b0;
            stretch_reg    <= 1'b0;
            armed_reg      <= 1'b0;
        end else begin
            if (count_set) begin
                count_flag_reg <= 1'b1;
            end else if (data_access | spi_new | powered_down) begin
                count_flag_reg <= 1'b0;
            end
            if (start_ev | stop_ev) begin
                stsp_flag_reg <= 1'b1;
            end else if ((wr_aux & sfr_wdata_in[ssp_pkg::AUX_STSP_BIT]) | powered_down) begin
                stsp_flag_reg <= 1'b0;
            end
            if (stretch_set) begin
                stretch_reg <= 1'b1;
            end else if (wr_tw | ~i2c_slave | tw_quiet) begin
                stretch_reg <= 1'b0;
            end
            // Software addressing arms the slave by writing the data register
            if (wr_tw & i2c_slave) begin
                armed_reg <= 1'b1;
            end else if (start_ev | stop_ev | ~i2c_slave) begin
                armed_reg <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sfr_rdata_out       <= 8'h00;
            sck_out             <= 1'b0;
            sck_oe_b_out        <= 1'b1;
            dout_out            <= 1'b1;
            dout_oe_b_out       <= 1'b1;
            gpio_release_out    <= 1'b1;
            count_event_out     <= 1'b0;
            startstop_event_out <= 1'b0;
        end else begin
            sfr_rdata_out       <= sfr_rd_in ? rdata_next : 8'h00;
            sck_out             <= sck_next;
            sck_oe_b_out        <= sck_oe_b_next;
            dout_out            <= dout_next;
            dout_oe_b_out       <= dout_oe_b_next;
            gpio_release_out    <= powered_down;
            count_event_out     <= count_flag_reg;
            startstop_event_out <= stsp_flag_reg;
        end
    end

endmodule : ssp_serial_port

// >>> core/ssp_pkg.sv
// Purpose: Shared constants and types for the serial port block
// Assumes: Registers sit on an 8-bit special-function register port
// Notes:   Offsets, field positions, counts and the control, power, clock-source and data reset values live here
package ssp_pkg;

    // Register offsets on the special-function register port
    localparam logic [7:0] SERIAL_CTRL_ADDR   = 8'h9A; // Mode bits and bit counter
    localparam logic [7:0] TWOWIRE_DATA_ADDR  = 8'h9B; // Shift register, two-wire view
    localparam logic [7:0] SERIAL_DATA_ADDR   = 8'h9C; // Shift register, SPI view
    localparam logic [7:0] AUX_INT_ADDR       = 8'hA6; // Pending event flags
    localparam logic [7:0] POWER_CTRL_ADDR    = 8'hF1; // Peripheral power control
    localparam logic [7:0] CLK_SRC_ADDR       = 8'hF2; // Serial clock source select

    // Field positions in the serial control register
    localparam int CTRL_I2C_BIT     = 0; // Two-wire mode
    localparam int CTRL_MASTER_BIT  = 1; // Master mode
    localparam int CTRL_CPOL_BIT    = 2; // Clock idle level
    localparam int CTRL_CPHA_BIT    = 3; // Clock phase
    localparam int CTRL_LSB_BIT     = 4; // Least significant bit first
    localparam int CTRL_ESS_BIT     = 5; // Slave-select gating enable
    localparam int CTRL_ONEBIT_BIT  = 6; // Event after every bit
    localparam int CTRL_NOSTR_BIT   = 7; // Stretch disable

    // Other field positions
    localparam int AUX_COUNT_BIT    = 2; // Count event flag
    localparam int AUX_STSP_BIT     = 3; // Start/stop event flag
    localparam int POWER_SER_BIT    = 0; // Serial power-down bit
    localparam int CLKSRC_SW_BIT    = 7; // Software clock level

    // Reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] POWER_RESET  = 8'h01; // Port powered down after reset
    localparam logic [7:0] CLKSRC_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;

    // Bit counter figures
    localparam logic [3:0] CNT_BYTE     = 4'h8; // Byte complete
    localparam logic [3:0] CNT_ACK      = 4'h9; // Acknowledge bit complete
    localparam logic [3:0] CNT_FIRST    = 4'h1; // First bit of a new byte
    localparam logic [7:0] DATA_RELEASE = 8'hFF; // Release line / arm / NACK

    // Master serial clock sources
    typedef enum logic [2:0] {
        SRC_SOFTWARE  = 3'h0,
        SRC_WR_PULSE  = 3'h1,
        SRC_WR_TOGGLE = 3'h2,
        SRC_T0_PULSE  = 3'h3,
        SRC_T0_TOGGLE = 3'h4,
        SRC_T1_PULSE  = 3'h5,
        SRC_T1_TOGGLE = 3'h6,
        SRC_IDLE      = 3'h7
    } ssp_clk_src_e;

    // Decoded control fields
    typedef struct packed {
        logic nostretch;
        logic onebit;
        logic select_gating_enable;
        logic lsb;
        logic cpha;
        logic cpol;
        logic master;
        logic i2c;
    } ssp_ctrl_s;

    // Line events crossing from the link domain
    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } ssp_evt_s;

endpackage : ssp_pkg

// >>> verif/ssp_serial_port_assertions.sv
// Purpose: Port-level checks for the serial port
// Assumes: Register side runs on the system clock only
// Notes:   Windows allow for the registered event outputs
module ssp_serial_port_assertions (
    input wire logic       ref_clk_in,
    input wire logic       rst_b_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       sck_oe_b_out,
    input wire logic       dout_oe_b_out,
    input wire logic       gpio_release_out,
    input wire logic       count_event_out,
    input wire logic       startstop_event_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Power-down requested on the register port
    sequence s_pd_wr;
        sfr_wr_in && sfr_addr_in == ssp_pkg::POWER_CTRL_ADDR && sfr_wdata_in[0];
    endsequence
    // Any access to the SPI data view
    sequence s_spi_acc;
        (sfr_wr_in || sfr_rd_in) && sfr_addr_in == ssp_pkg::SERIAL_DATA_ADDR;
    endsequence
    property p_pd_on; s_pd_wr |-> ##[1:3] gpio_release_out; endproperty
    a_pd_on: assert property (p_pd_on) else $error("pins not released");
    // One cycle of grace while the enables follow the release
    property p_pd_pins;
        gpio_release_out && $past(gpio_release_out) |-> sck_oe_b_out && dout_oe_b_out;
    endproperty
    a_pd_pins: assert property (p_pd_pins) else $error("pin driven in power-down");
    property p_spi_clr; s_spi_acc |-> ##[2:3] !count_event_out; endproperty
    a_spi_clr: assert property (p_spi_clr) else $error("count flag kept");
    property p_tw_clr;
        sfr_wr_in && sfr_addr_in == ssp_pkg::TWOWIRE_DATA_ADDR |-> ##[2:3] !count_event_out;
    endproperty
    a_tw_clr: assert property (p_tw_clr) else $error("two-wire flag kept");
    // Start/stop flag only drops after a register write
    property p_ss_fall;
        $fell(startstop_event_out) |-> $past(sfr_wr_in, 1) || $past(sfr_wr_in, 2)
            || $past(sfr_wr_in, 3);
    endproperty
    a_ss_fall: assert property (p_ss_fall) else $error("start flag lost");
    property p_count_rise; $rose(count_event_out) |-> !gpio_release_out; endproperty
    a_count_rise: assert property (p_count_rise) else $error("flag while off");
    property p_rd_idle; !sfr_rd_in |=> sfr_rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data held");
    property p_ss_rise; $rose(startstop_event_out) |-> !gpio_release_out; endproperty
    a_ss_rise: assert property (p_ss_rise) else $error("start flag while off");
endmodule : ssp_serial_port_assertions
bind ssp_serial_port ssp_serial_port_assertions ssp_serial_port_assertions_inst (
    .ref_clk_in, .rst_b_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
    .sfr_rdata_out, .sck_oe_b_out, .dout_oe_b_out, .gpio_release_out,
    .count_event_out, .startstop_event_out);

// >>> verif/ssp_spi_model.sv
// Purpose: Far-end master for SPI mode 0 and two-wire start
// Assumes: Clock idles low and stands still between frames
// Notes:   Half period of 200 ns keeps edges apart at the link
module ssp_spi_model (
    input  wire logic miso_in,  // Data from the slave
    output logic      sck_out,  // Serial clock
    output logic      mosi_out, // Data to the slave, SDA in two-wire
    output logic      ss_b_out  // Slave-select, active low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx = 8'h00; // Received shift history
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b1;
        ss_b_out = 1'b1;
    end
    // Select held across whole frames
    task sel(input logic v);
        ss_b_out = v;
    endtask : sel
    // Send n bits from the top of tx, sample on rise
    task xfer(input logic [7:0] tx, input int n);
        for (int i = 0; i < n; i++) begin
            mosi_out = tx[7-i];
            #200 sck_out = 1'b1;
            rx = {rx[6:0], miso_in};
            #200 sck_out = 1'b0;
        end
    endtask : xfer
    // Data falls with clock high; addressing is left to software
    task start_cond();
        mosi_out = 1'b1;
        #200 sck_out = 1'b1;
        #200 mosi_out = 1'b0;
        #200;
    endtask : start_cond
endmodule : ssp_spi_model

// >>> verif/ssp_serial_port_tb_top.sv
// Purpose: Scenario bench for the serial port
// Assumes: Slave transfers; own clock from software and timer 0
// Notes:   Wires resolve open-drain drive in two-wire mode
module ssp_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 0, rst_b_in = 0, link_clk_in = 0, sfr_wr_in = 0, sfr_rd_in = 0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
    logic sck_out, sck_oe_b_out, dout_out, dout_oe_b_out, gpio_release_out;
    logic count_event_out, startstop_event_out, ss_b_in, m_sck, m_mosi, tw = 0;
    int fails = 0, compares = 0;
    logic timer0_expiry_in = 0, timer1_expiry_in = 0, ext_move_wr_in = 0;
    // Pull-up wires: low when either party pulls
    wire logic sck_in = m_sck & (sck_oe_b_out | sck_out);
    wire logic din_in = m_mosi & (dout_oe_b_out | dout_out | !tw);
    always #5 ref_clk_in = ~ref_clk_in;
    // Link clock offset so edges never line up
    initial begin
        #2.3;
        forever #7.5 link_clk_in = ~link_clk_in;
    end
    ssp_serial_port ssp_serial_port_inst (.ref_clk_in, .rst_b_in, .link_clk_in,
        .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out,
        .timer0_expiry_in, .timer1_expiry_in, .ext_move_wr_in, .ss_b_in, .sck_in,
        .din_in, .sck_out, .sck_oe_b_out, .dout_out, .dout_oe_b_out,
        .gpio_release_out, .count_event_out, .startstop_event_out);
    ssp_spi_model ssp_spi_model_inst (.miso_in(dout_oe_b_out ? ~dout_out : dout_out), .sck_out(m_sck),
        .mosi_out(m_mosi), .ss_b_out(ss_b_in));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in) #1 {sfr_wr_in, sfr_addr_in, sfr_wdata_in} = {1'b1, a, d};
        @(posedge ref_clk_in) #1 sfr_wr_in = 1'b0;
    endtask : wr
    // Read data stands in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in) #1 {sfr_rd_in, sfr_addr_in} = {1'b1, a};
        @(posedge ref_clk_in) #1 sfr_rd_in = 1'b0;
        chk(sfr_rdata_out, exp);
    endtask : rd
    task report_and_stop();
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task t_reset();
        chk({7'h0, gpio_release_out}, 8'h01);
        rd(8'hF1, 8'h01);
        rd(8'h00, 8'h00);
    endtask : t_reset
    // Split byte with a counter read in mid-frame
    task t_spi();
        wr(8'hF1, 8'h00);
        wr(8'h9A, 8'h20);
        wr(8'h9C, 8'hA5);
        ssp_spi_model_inst.sel(1'b0);
        #300 chk({7'h0, dout_oe_b_out}, 8'h00);
        ssp_spi_model_inst.xfer(8'h3C, 4);
        rd(8'h9A, 8'h24);
        ssp_spi_model_inst.xfer(8'hC0, 4);
        #300 chk({7'h0, count_event_out}, 8'h01);
        chk(ssp_spi_model_inst.rx, 8'hA5);
        rd(8'h9C, 8'h3C);
        #50 chk({7'h0, count_event_out}, 8'h00);
    endtask : t_spi
    // Unread byte followed by a new frame
    task t_over();
        ssp_spi_model_inst.xfer(8'h00, 8);
        #300 chk({7'h0, count_event_out}, 8'h01);
        ssp_spi_model_inst.xfer(8'h80, 1);
        #300 chk({7'h0, count_event_out}, 8'h00);
        rd(8'h9A, 8'h21);
        rd(8'h9C, 8'h01);
    endtask : t_over
    // Deselected slave ignores a full frame
    task t_gate();
        ssp_spi_model_inst.sel(1'b1);
        wr(8'h9C, 8'h00);
        #300 chk({7'h0, dout_oe_b_out}, 8'h01);
        ssp_spi_model_inst.xfer(8'hFF, 8);
        #300 chk({7'h0, count_event_out}, 8'h00);
        rd(8'h9A, 8'h20);
        rd(8'h9C, 8'h00);
    endtask : t_gate
    task t_tw();
        tw = 1'b1;
        wr(8'h9A, 8'h01);
        wr(8'h9B, 8'hFF);
        ssp_spi_model_inst.xfer(8'hC0, 2);
        ssp_spi_model_inst.start_cond();
        #300 chk({7'h0, startstop_event_out}, 8'h01);
        rd(8'h9A, 8'h00);
        wr(8'hA6, 8'h08);
        #50 chk({7'h0, startstop_event_out}, 8'h00);
    endtask : t_tw
    task t_pd();
        wr(8'h9A, 8'h02);
        wr(8'hF2, 8'h80);
        #50 chk({7'h0, sck_out}, 8'h01);
        wr(8'hF2, 8'h04);
        @(posedge ref_clk_in) #1 timer0_expiry_in = 1'b1;
        @(posedge ref_clk_in) #1 timer0_expiry_in = 1'b0;
        #50 chk({7'h0, sck_out}, 8'h00);
        wr(8'hF1, 8'h01);
        #50 chk({5'h0, gpio_release_out, dout_oe_b_out, sck_oe_b_out}, 8'h07);
    endtask : t_pd
    initial begin
        repeat (5) @(posedge ref_clk_in);
        #1 rst_b_in = 1'b1;
        t_reset();
        t_spi();
        t_over();
        t_gate();
        t_tw();
        t_pd();
        report_and_stop();
    end
    // Hang guard well past the expected run
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule : ssp_serial_port_tb_top
